/* core/uic_consts.vh */
// Constants for the universal input conditioner: register map, reset values,
// parameter limits and fixed scaling figures. Definitions only.
`ifndef UIC_CONSTS_VH
`define UIC_CONSTS_VH

// Register byte offsets on the APB bus
`define UIC_ADDR_INPUT_OFFSET 8'h00
`define UIC_ADDR_CAL_RATIO 8'h04
`define UIC_ADDR_UPPER_CLAMP 8'h08
`define UIC_ADDR_LOWER_CLAMP 8'h0c
`define UIC_ADDR_LINEAR_DEST 8'h10
`define UIC_ADDR_LOGIC1_DEST 8'h14
`define UIC_ADDR_LOGIC2_DEST 8'h18
`define UIC_ADDR_LOGIC1_HIGH 8'h1c
`define UIC_ADDR_LOGIC1_LOW 8'h20
`define UIC_ADDR_LOGIC2_HIGH 8'h24
`define UIC_ADDR_LOGIC2_LOW 8'h28
`define UIC_ADDR_THRESHOLD 8'h2c
`define UIC_ADDR_RANGE 8'h30
`define UIC_ADDR_STATUS 8'h34

// Percent values carry 0.01 % per count, ratio 0.0001 per count, volts 1 mV
`define UIC_RST_OFFSET 16'h0000
`define UIC_RST_RATIO 16'h2710
`define UIC_RST_UPPER 16'h2710
`define UIC_RST_LOWER 16'hd8f0
`define UIC_RST_LOGIC_VAL 16'h0001
`define UIC_RST_THRESHOLD 16'h1770
`define UIC_RST_RANGE 2'h0

`define UIC_OFFSET_MAX 16'h2710
`define UIC_RATIO_MAX 16'h7530
`define UIC_PCT300_MAX 16'h7530
`define UIC_THRESHOLD_MAX 16'h7530
`define UIC_DEST_MAX 16'h02d0

// Input ranges and their full-scale voltage in mV
`define UIC_RANGE_10V 2'h0
`define UIC_RANGE_5V 2'h1
`define UIC_RANGE_20V 2'h2
`define UIC_RANGE_30V 2'h3
`define UIC_FS_5V 36'h000001388
`define UIC_FS_10V 36'h000002710
`define UIC_FS_20V 36'h000004e20
`define UIC_FS_30V 36'h000007530
`define UIC_PCT_FULL 36'h000002710
`define UIC_RATIO_UNIT 36'h000002710

// Destination parameter numbers
`define UIC_DEST_NULL 16'h0190
`define UIC_DEST_SPEED_REF2 16'h003f
`define UIC_DEST_RAMP_IN 16'h001a
`define UIC_DEST_LOWER_CUR 16'h005a
`define UIC_DEST_UPPER_CUR 16'h0059
`define UIC_DEST_MOTOR_POT_PRESET 16'h0034
`define UIC_DEST_MP_RAISE 16'h0030
`define UIC_DEST_MP_LOWER 16'h0031

`endif

/* core/universal_input_conditioner.v */
// Conditioning path for one universal input channel with an APB register file.
// Assumes one digitised sample in mV per i_sample_valid pulse, synchronous to i_clk.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`include "uic_consts.vh"

module universal_input_conditioner #(
    parameter CHANNEL = 2,
    parameter DW = 16
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_sample_valid,
    input wire signed [DW-1:0] i_sample_mv,
    output reg o_update,
    output reg signed [DW-1:0] o_linear_value,
    output reg [DW-1:0] o_linear_dest,
    output reg signed [DW-1:0] o_logic1_value,
    output reg o_logic1_bit,
    output reg [DW-1:0] o_logic1_dest,
    output reg signed [DW-1:0] o_logic2_value,
    output reg o_logic2_bit,
    output reg [DW-1:0] o_logic2_dest,
    output reg o_threshold_high
);

    // Out-of-range writes saturate so the arithmetic widths below stay valid
    function [DW-1:0] sat;
        input [31:0] value;
        input [DW-1:0] lo;
        input [DW-1:0] hi;
        reg signed [31:0] v;
        begin
            v = value;
            if (v > $signed({16'h0000, hi})) begin
                sat = hi;
            end else if (v < $signed({{16{lo[DW-1]}}, lo})) begin
                sat = lo;
            end else begin
                sat = value[DW-1:0];
            end
        end
    endfunction

    function [DW-1:0] lin_dest_default;
        input integer ch;
        begin
            case (ch)
                2: lin_dest_default = `UIC_DEST_SPEED_REF2;
                4: lin_dest_default = `UIC_DEST_RAMP_IN;
                5: lin_dest_default = `UIC_DEST_LOWER_CUR;
                6: lin_dest_default = `UIC_DEST_UPPER_CUR;
                default: lin_dest_default = `UIC_DEST_NULL;
            endcase
        end
    endfunction

    function [DW-1:0] logic1_dest_default;
        input integer ch;
        begin
            case (ch)
                7: logic1_dest_default = `UIC_DEST_MOTOR_POT_PRESET;
                8: logic1_dest_default = `UIC_DEST_MP_RAISE;
                9: logic1_dest_default = `UIC_DEST_MP_LOWER;
                default: logic1_dest_default = `UIC_DEST_NULL;
            endcase
        end
    endfunction

    localparam [DW-1:0] LIN_DEST_RST = lin_dest_default(CHANNEL);
    localparam [DW-1:0] LOG1_DEST_RST = logic1_dest_default(CHANNEL);
    localparam [DW-1:0] ZERO = 16'h0000;

    reg [DW-1:0] input_offset;
    reg [DW-1:0] calibration_ratio;
    reg [DW-1:0] upper_clamp;
    reg [DW-1:0] lower_clamp;
    reg [DW-1:0] linear_destination;
    reg [DW-1:0] logic1_destination;
    reg [DW-1:0] logic2_destination;
    reg [DW-1:0] logic1_high_value;
    reg [DW-1:0] logic1_low_value;
    reg [DW-1:0] logic2_high_value;
    reg [DW-1:0] logic2_low_value;
    reg [DW-1:0] threshold;
    reg [1:0] range_select;

    wire wr_en;
    wire rd_setup;
    reg addr_hit;
    reg [31:0] rd_value;

    // Zero wait states: every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_hit;
    assign wr_en = i_psel & i_penable & i_pwrite & addr_hit;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

    always @* begin
        addr_hit = 1'b1;
        rd_value = 32'h00000000;
        case (i_paddr)
            `UIC_ADDR_INPUT_OFFSET: rd_value = {{16{input_offset[DW-1]}}, input_offset};
            `UIC_ADDR_CAL_RATIO: rd_value = {{16{calibration_ratio[DW-1]}}, calibration_ratio};
            `UIC_ADDR_UPPER_CLAMP: rd_value = {{16{upper_clamp[DW-1]}}, upper_clamp};
            `UIC_ADDR_LOWER_CLAMP: rd_value = {{16{lower_clamp[DW-1]}}, lower_clamp};
            `UIC_ADDR_LINEAR_DEST: rd_value = {16'h0000, linear_destination};
            `UIC_ADDR_LOGIC1_DEST: rd_value = {16'h0000, logic1_destination};
            `UIC_ADDR_LOGIC2_DEST: rd_value = {16'h0000, logic2_destination};
            `UIC_ADDR_LOGIC1_HIGH: rd_value = {{16{logic1_high_value[DW-1]}}, logic1_high_value};
            `UIC_ADDR_LOGIC1_LOW: rd_value = {{16{logic1_low_value[DW-1]}}, logic1_low_value};
            `UIC_ADDR_LOGIC2_HIGH: rd_value = {{16{logic2_high_value[DW-1]}}, logic2_high_value};
            `UIC_ADDR_LOGIC2_LOW: rd_value = {{16{logic2_low_value[DW-1]}}, logic2_low_value};
            `UIC_ADDR_THRESHOLD: rd_value = {{16{threshold[DW-1]}}, threshold};
            `UIC_ADDR_RANGE: rd_value = {30'h00000000, range_select};
            `UIC_ADDR_STATUS: rd_value = {15'h0000, o_threshold_high, o_linear_value};
            default: addr_hit = 1'b0;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (rd_setup) begin
            o_prdata <= rd_value;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            input_offset <= `UIC_RST_OFFSET;
            calibration_ratio <= `UIC_RST_RATIO;
            upper_clamp <= `UIC_RST_UPPER;
            lower_clamp <= `UIC_RST_LOWER;
            linear_destination <= LIN_DEST_RST;
            logic1_destination <= LOG1_DEST_RST;
            logic2_destination <= `UIC_DEST_NULL;
            logic1_high_value <= `UIC_RST_LOGIC_VAL;
            logic1_low_value <= `UIC_RST_LOGIC_VAL;
            logic2_high_value <= `UIC_RST_LOGIC_VAL;
            logic2_low_value <= `UIC_RST_LOGIC_VAL;
            threshold <= `UIC_RST_THRESHOLD;
            range_select <= `UIC_RST_RANGE;
        end else if (wr_en) begin
            case (i_paddr)
                `UIC_ADDR_INPUT_OFFSET:
                    input_offset <= sat(i_pwdata, -`UIC_OFFSET_MAX, `UIC_OFFSET_MAX);
                `UIC_ADDR_CAL_RATIO:
                    calibration_ratio <= sat(i_pwdata, -`UIC_RATIO_MAX, `UIC_RATIO_MAX);
                `UIC_ADDR_UPPER_CLAMP:
                    upper_clamp <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_LOWER_CLAMP:
                    lower_clamp <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_LINEAR_DEST:
                    linear_destination <= sat(i_pwdata, ZERO, `UIC_DEST_MAX);
                `UIC_ADDR_LOGIC1_DEST:
                    logic1_destination <= sat(i_pwdata, ZERO, `UIC_DEST_MAX);
                `UIC_ADDR_LOGIC2_DEST:
                    logic2_destination <= sat(i_pwdata, ZERO, `UIC_DEST_MAX);
                `UIC_ADDR_LOGIC1_HIGH:
                    logic1_high_value <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_LOGIC1_LOW:
                    logic1_low_value <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_LOGIC2_HIGH:
                    logic2_high_value <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_LOGIC2_LOW:
                    logic2_low_value <= sat(i_pwdata, -`UIC_PCT300_MAX, `UIC_PCT300_MAX);
                `UIC_ADDR_THRESHOLD:
                    threshold <= sat(i_pwdata, -`UIC_THRESHOLD_MAX, `UIC_THRESHOLD_MAX);
                `UIC_ADDR_RANGE:
                    range_select <= i_pwdata[1:0];
                default: range_select <= range_select;
            endcase
        end
    end

    // One count of offset is 0.01 % of 10 V, i.e. 1 mV, in every range
    wire signed [35:0] corrected_mv;
    reg signed [35:0] full_scale;
    wire signed [35:0] percent;
    wire signed [35:0] scaled;
    reg signed [35:0] clamped;
    wire above;

    assign corrected_mv = i_sample_mv + $signed(input_offset);

    always @* begin
        case (range_select)
            `UIC_RANGE_5V: full_scale = `UIC_FS_5V;
            `UIC_RANGE_20V: full_scale = `UIC_FS_20V;
            `UIC_RANGE_30V: full_scale = `UIC_FS_30V;
            default: full_scale = `UIC_FS_10V;
        endcase
    end

    // Full scale in the chosen range maps to 100.00 % before the ratio
    assign percent = (corrected_mv * $signed(`UIC_PCT_FULL)) / full_scale;
    // Signed product, so a negative ratio flips polarity
    assign scaled = (percent * $signed(calibration_ratio)) / $signed(`UIC_RATIO_UNIT);

    // Upper limit first; the lower limit wins if software sets them crossed
    always @* begin
        clamped = scaled;
        if (clamped > $signed(upper_clamp)) begin
            clamped = $signed(upper_clamp);
        end
        if (clamped < $signed(lower_clamp)) begin
            clamped = $signed(lower_clamp);
        end
    end

    // Raw sample only: neither offset nor ratio touches the comparison
    assign above = i_sample_mv > $signed(threshold);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_update <= 1'b0;
            o_linear_value <= ZERO;
            o_linear_dest <= LIN_DEST_RST;
            o_logic1_value <= `UIC_RST_LOGIC_VAL;
            o_logic1_bit <= 1'b1;
            o_logic1_dest <= LOG1_DEST_RST;
            o_logic2_value <= `UIC_RST_LOGIC_VAL;
            o_logic2_bit <= 1'b1;
            o_logic2_dest <= `UIC_DEST_NULL;
            o_threshold_high <= 1'b0;
        end else begin
            o_update <= i_sample_valid;
            if (i_sample_valid) begin
                o_linear_value <= clamped[DW-1:0];
                o_linear_dest <= linear_destination;
                o_logic1_dest <= logic1_destination;
                o_logic2_dest <= logic2_destination;
                o_threshold_high <= above;
                if (above) begin
                    o_logic1_value <= logic1_high_value;
                    o_logic1_bit <= |logic1_high_value;
                    o_logic2_value <= logic2_high_value;
                    o_logic2_bit <= |logic2_high_value;
                end else begin
                    o_logic1_value <= logic1_low_value;
                    o_logic1_bit <= |logic1_low_value;
                    o_logic2_value <= logic2_low_value;
                    o_logic2_bit <= |logic2_low_value;
                end
            end
        end
    end

endmodule

/* test/uic_chk.sv */
// Assertions on the conditioner's sample and output ports.
// Assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/10ps
module uic_chk #(
    parameter DW = 16
) (
    input logic i_clk,
    input logic i_rst_n,
    input logic i_psel,
    input logic i_sample_valid,
    input logic o_update,
    input logic signed [DW-1:0] o_linear_value,
    input logic [DW-1:0] o_linear_dest,
    input logic signed [DW-1:0] o_logic1_value,
    input logic o_logic1_bit,
    input logic [DW-1:0] o_logic1_dest,
    input logic signed [DW-1:0] o_logic2_value,
    input logic o_logic2_bit,
    input logic [DW-1:0] o_logic2_dest,
    input logic o_threshold_high
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    upd_follow_a: assert property (i_sample_valid |=> o_update)
        else $error("update pulse missing");
    upd_only_a: assert property (!i_sample_valid |=> !o_update)
        else $error("update without sample");
    out_hold_a: assert property (!i_sample_valid |=>
        $stable(o_linear_value) && $stable(o_threshold_high)) else $error("outputs moved");
    bit_one_a: assert property (o_update |-> o_logic1_bit == (o_logic1_value != 0))
        else $error("logic 1 level wrong");
    bit_two_a: assert property (o_update |-> o_logic2_bit == (o_logic2_value != 0))
        else $error("logic 2 level wrong");
    lin_range_a: assert property (o_update |-> o_linear_value <= 16'sh7530 &&
        o_linear_value >= 16'sh8ad0) else $error("linear result out of range");
    dest_range_a: assert property (o_linear_dest <= 16'h02d0 &&
        o_logic1_dest <= 16'h02d0 && o_logic2_dest <= 16'h02d0) else $error("bad destination");
    // Two back-to-back samples on the same side of the threshold, with no register access, must pick the same pair
    sel_same_a: assert property (o_update && $past(o_update) && $stable(o_threshold_high) &&
        !$past(i_psel) && !$past(i_psel, 2) |-> $stable(o_logic1_value) &&
        $stable(o_logic2_value)) else $error("logic value changed");
endmodule

bind universal_input_conditioner uic_chk #(.DW(DW)) uic_chk_i (.i_clk, .i_rst_n, .i_psel,
    .i_sample_valid, .o_update, .o_linear_value, .o_linear_dest, .o_logic1_value,
    .o_logic1_bit, .o_logic1_dest, .o_logic2_value, .o_logic2_bit, .o_logic2_dest,
    .o_threshold_high);

/* test/uic_dest_model.sv */
// Far-side stand-in: parameter slots written by the routed results.
// Assumes the update pulse marks every routed output as new.
`timescale 1ns/10ps
module uic_dest_model (
    input logic i_clk,
    input logic i_update,
    input logic [15:0] i_lin,
    input logic [15:0] i_lin_dest,
    input logic [15:0] i_v1,
    input logic [15:0] i_d1,
    input logic [15:0] i_v2,
    input logic [15:0] i_d2,
    input logic [15:0] i_q,
    output logic [15:0] o_q
);
    logic [15:0] slot [0:1023];
    // A logic slot keeps only the level, so a value of any sign reads as high
    always @(posedge i_clk) begin
        if (i_update) begin
            slot[i_lin_dest[9:0]] <= i_lin;
            slot[i_d1[9:0]] <= {15'h0000, i_v1 != 16'h0000};
            slot[i_d2[9:0]] <= {15'h0000, i_v2 != 16'h0000};
        end
    end
    assign o_q = slot[i_q[9:0]];
endmodule

/* test/universal_input_conditioner_test.sv */
// Self-checking bench for the universal input conditioner.
// Assumes the conditioner's constants header and the far-side slot model.
`timescale 1ns/10ps
`include "uic_consts.vh"
module universal_input_conditioner_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_sample_valid = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h00000000;
    logic signed [15:0] i_sample_mv = 16'sh0000;
    logic [31:0] o_prdata, rd;
    logic o_pready, o_pslverr, o_update, o_logic1_bit, o_logic2_bit, o_threshold_high, er;
    logic signed [15:0] o_linear_value, o_logic1_value, o_logic2_value;
    logic [15:0] o_linear_dest, o_logic1_dest, o_logic2_dest, q, q_val;
    logic [127:0] row;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    // Range, offset, ratio, upper, lower, sample, linear result, above threshold
    logic [127:0] rows [0:9] = '{128'h0000_0000_2710_2710_d8f0_2710_2710_0001,
        128'h0001_0000_2710_2710_d8f0_1388_2710_0000, 128'h0001_07d0_2710_2710_d8f0_03e8_1770_0000,
        128'h0000_2710_2710_2710_d8f0_1388_2710_0000, 128'h0000_0000_d8f0_7530_8ad0_1b58_e4a8_0001,
        128'h0002_0000_7530_7530_8ad0_4e20_7530_0001, 128'h0000_0000_2710_2710_ec78_e0c0_ec78_0000,
        128'h0003_0000_2710_2710_d8f0_1770_07d0_0000, 128'h0003_0000_2710_2710_d8f0_1771_07d0_0001,
        128'h0000_03e8_4e20_2710_d8f0_07d0_1770_0000};
    logic [15:0] rst_tab [0:10] = '{16'h0000, 16'h2710, 16'h2710, 16'hd8f0, 16'h003f, 16'h0190,
        16'h0190, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
    always #12.5 i_clk = ~i_clk;
    universal_input_conditioner #(.CHANNEL(2)) universal_input_conditioner_i (.i_clk, .i_rst_n,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_sample_valid, .i_sample_mv, .o_update, .o_linear_value, .o_linear_dest,
        .o_logic1_value, .o_logic1_bit, .o_logic1_dest, .o_logic2_value, .o_logic2_bit,
        .o_logic2_dest, .o_threshold_high);
    uic_dest_model uic_dest_model_i (.i_clk, .i_update(o_update), .i_lin(o_linear_value),
        .i_lin_dest(o_linear_dest), .i_v1(o_logic1_value), .i_d1(o_logic1_dest),
        .i_v2(o_logic2_value), .i_d2(o_logic2_dest), .i_q(q), .o_q(q_val));
    task chk16(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {{16{d[15]}}, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1)
            @(posedge i_clk);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task sample(input logic [15:0] v);
        @(posedge i_clk);
        i_sample_valid <= 1'b1;
        i_sample_mv <= v;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        @(negedge i_clk);
    endtask
    task end_of_test;
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        q = 16'h0000;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk16(o_linear_dest, `UIC_DEST_SPEED_REF2);
        chk16(o_logic1_dest, `UIC_DEST_NULL);
        chk16(o_logic2_dest, `UIC_DEST_NULL);
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, 8'(4 * i), 16'h0000);
            chk16(rd[15:0], rst_tab[i]);
        end
        apb(1'b0, 8'h3c, 16'h0000);
        chk1(er, 1'b1);
        apb(1'b1, `UIC_ADDR_LOGIC1_HIGH, 16'h0064);
        apb(1'b1, `UIC_ADDR_LOGIC1_LOW, 16'h0000);
        apb(1'b1, `UIC_ADDR_LOGIC2_HIGH, 16'h0000);
        apb(1'b1, `UIC_ADDR_LOGIC2_LOW, 16'hffff);
        for (int i = 0; i < 10; i++) begin
            row = rows[i];
            apb(1'b1, `UIC_ADDR_RANGE, row[127:112]);
            for (int k = 1; k < 5; k++)
                apb(1'b1, 8'(4 * k - 4), row[127 - 16 * k -: 16]);
            sample(row[47:32]);
            chk1(o_update, 1'b1);
            chk16(o_linear_value, row[31:16]);
            chk1(o_threshold_high, row[0]);
            chk16(o_logic1_value, row[0] ? 16'h0064 : 16'h0000);
            chk16(o_logic2_value, row[0] ? 16'h0000 : 16'hffff);
        end
        apb(1'b1, `UIC_ADDR_LINEAR_DEST, 16'h02d1);
        apb(1'b1, `UIC_ADDR_LOGIC1_DEST, `UIC_DEST_MOTOR_POT_PRESET);
        apb(1'b1, `UIC_ADDR_LOGIC2_DEST, `UIC_DEST_MP_RAISE);
        apb(1'b0, `UIC_ADDR_LINEAR_DEST, 16'h0000);
        chk16(rd[15:0], 16'h02d0);
        sample(16'h2710);
        q = 16'h02d0;
        @(negedge i_clk);
        chk16(q_val, 16'h2710);
        q = `UIC_DEST_MOTOR_POT_PRESET;
        #1 chk16(q_val, 16'h0001);
        q = `UIC_DEST_MP_RAISE;
        #1 chk16(q_val, 16'h0000);
        @(posedge i_clk);
        i_sample_valid <= 1'b1;
        i_sample_mv <= 16'h1771;
        @(posedge i_clk);
        i_sample_mv <= 16'h1b58;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        @(negedge i_clk);
        chk1(o_update, 1'b1);
        chk16(o_linear_value, 16'h2710);
        end_of_test;
    end
endmodule
